// ===== rtl/dscg_top.sv
// deep-sleep clock gate bank: gate register, unit clock enables and bus fault screening
// assumes an axi4-lite master on aclk and run/sleep enable sets from companion logic on aclk
//
// Implementation choice: register access over AXI4-Lite.
`include "dscg_defs.svh"

module dscg_top #(
   parameter int ADDR_W = 12,
   parameter int N = `DSCG_UNITS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire dscg_pkg::dscg_pmode_t power_mode,
   input wire logic auto_clock_gate_select,
   input wire logic [N-1:0] run_gate_reg0,
   input wire logic [N-1:0] sleep_gate_reg0,
   input wire logic [N-1:0] unit_access_valid,
   output logic [N-1:0] unit_clk_en,
   output logic [N-1:0] unit_access_fault,
   output logic [N-1:0] unit_access_ok
);
   import dscg_pkg::*;

   // ----------------------------------------------------------------------------
   // field mapping between unit vectors and register bit positions
   // ----------------------------------------------------------------------------
   function automatic logic [31:0] units_to_reg(input logic [N-1:0] u);
      logic [31:0] r;
      r = `DSCG_ZERO32;
      r[`DSCG_BIT_WDOG] = u[`DSCG_U_WDOG];
      r[`DSCG_BIT_HIB] = u[`DSCG_U_HIB];
      r[`DSCG_BIT_ADC0] = u[`DSCG_U_ADC0];
      r[`DSCG_BIT_CAN_UNIT0_GATE] = u[`DSCG_U_CAN_UNIT0_GATE];
      return r;
   endfunction

   function automatic logic [N-1:0] reg_to_units(input logic [31:0] r);
      logic [N-1:0] u;
      u = '0;
      u[`DSCG_U_WDOG] = r[`DSCG_BIT_WDOG];
      u[`DSCG_U_HIB] = r[`DSCG_BIT_HIB];
      u[`DSCG_U_ADC0] = r[`DSCG_BIT_ADC0];
      u[`DSCG_U_CAN_UNIT0_GATE] = r[`DSCG_BIT_CAN_UNIT0_GATE];
      return u;
   endfunction

   function automatic logic [`DSCG_FCNT_W-1:0] count_ones(input logic [N-1:0] v);
      logic [`DSCG_FCNT_W-1:0] c;
      c = `DSCG_FCNT_ZERO;
      for (int k = 0; k < N; k++) begin
         c = c + {{(`DSCG_FCNT_W-1){1'b0}}, v[k]};
      end
      return c;
   endfunction

   // one-hot register hit for a byte address: {fault count, status, gate}
   function automatic logic [2:0] reg_hit(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] w;
      w = {a[ADDR_W-1:2], 2'b00};
      return {w == ADDR_W'(`DSCG_OFF_FAULT_CNT), w == ADDR_W'(`DSCG_OFF_STATUS),
              w == ADDR_W'(`DSCG_OFF_DEEP_GATE)};
   endfunction

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   logic [N-1:0] deep_gate_q;
   logic [N-1:0] deep_gate_d;
   logic [N-1:0] unit_clk_en_q;
   logic [N-1:0] unit_access_fault_q;
   logic [N-1:0] unit_access_ok_q;
   logic [`DSCG_FCNT_W-1:0] fault_cnt_q;
   logic [`DSCG_FCNT_W-1:0] fault_cnt_d;

   dscg_wr_state_t wr_state_q;
   dscg_wr_state_t wr_state_d;
   logic have_aw_q;
   logic have_w_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q;

   dscg_rd_state_t rd_state_q;
   dscg_rd_state_t rd_state_d;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // ----------------------------------------------------------------------------
   // enable selection across the three sets
   // ----------------------------------------------------------------------------
   wire [N-1:0] sel_unit_en;

   dscg_gate_select #(
      .N(N)
   ) u_gate_select (
      .power_mode(power_mode),
      .auto_clock_gate_select(auto_clock_gate_select),
      .run_en(run_gate_reg0),
      .sleep_en(sleep_gate_reg0),
      .deep_en(deep_gate_q),
      .unit_en(sel_unit_en)
   );

   // ----------------------------------------------------------------------------
   // write channel decode
   // ----------------------------------------------------------------------------
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire aw_ready_now = have_aw_q || aw_take;
   wire w_ready_now = have_w_q || w_take;
   wire [ADDR_W-1:0] wr_addr = have_aw_q ? awaddr_q : s_axi_awaddr;
   wire [31:0] wr_data = have_w_q ? wdata_q : s_axi_wdata;
   wire [3:0] wr_strb = have_w_q ? wstrb_q : s_axi_wstrb;
   wire wr_fire = (wr_state_q == DSCG_WR_IDLE) && aw_ready_now && w_ready_now;
   wire [2:0] wr_hit = reg_hit(wr_addr);
   wire wr_hit_deep = wr_hit[0];
   wire wr_hit_stat = wr_hit[1];
   wire wr_hit_fcnt = wr_hit[2];
   wire wr_mapped = wr_hit_deep || wr_hit_stat || wr_hit_fcnt;
   wire [31:0] wr_bytemask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

   // only the implemented gate bits take written data; the rest stay zero
   wire [31:0] deep_cur = units_to_reg(deep_gate_q);
   wire [31:0] deep_mask = wr_bytemask & `DSCG_DEEP_WMASK;
   wire [31:0] deep_new = (deep_cur & ~deep_mask) | (wr_data & deep_mask);
   wire deep_we = wr_fire && wr_hit_deep;
   wire fcnt_clr = wr_fire && wr_hit_fcnt && (wr_strb != 4'h0);

   // ----------------------------------------------------------------------------
   // read channel decode
   // ----------------------------------------------------------------------------
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire [2:0] rd_hit = reg_hit(s_axi_araddr);
   wire rd_hit_deep = rd_hit[0];
   wire rd_hit_stat = rd_hit[1];
   wire rd_hit_fcnt = rd_hit[2];
   wire rd_mapped = rd_hit_deep || rd_hit_stat || rd_hit_fcnt;
   wire [31:0] fcnt_word = {{(32-`DSCG_FCNT_W){1'b0}}, fault_cnt_q};
   // reserved bits read as zero through the field map
   wire [31:0] rd_value = rd_hit_deep ? deep_cur :
                          rd_hit_stat ? units_to_reg(unit_clk_en_q) :
                          rd_hit_fcnt ? fcnt_word : `DSCG_ZERO32;

   // ----------------------------------------------------------------------------
   // unit access screening
   // ----------------------------------------------------------------------------
   // a unit is screened against the enable it currently receives
   wire [N-1:0] access_fault_now = unit_access_valid & ~unit_clk_en_q;
   wire [N-1:0] access_ok_now = unit_access_valid & unit_clk_en_q;
   wire [`DSCG_FCNT_W-1:0] fault_inc = count_ones(access_fault_now);

   // ----------------------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------------------
   assign deep_gate_d = deep_we ? reg_to_units(deep_new) : deep_gate_q;

   // a fault in the clearing cycle still counts
   assign fault_cnt_d = (fcnt_clr ? `DSCG_FCNT_ZERO : fault_cnt_q) + fault_inc;

   always_comb begin
      wr_state_d = wr_state_q;
      unique case (wr_state_q)
         DSCG_WR_IDLE: begin
            if (wr_fire) begin
               wr_state_d = DSCG_WR_RESP;
            end
         end
         DSCG_WR_RESP: begin
            if (s_axi_bready) begin
               wr_state_d = DSCG_WR_IDLE;
            end
         end
         // codes that are not one-hot fall back to idle
         default: begin
            wr_state_d = DSCG_WR_IDLE;
         end
      endcase
   end

   always_comb begin
      rd_state_d = rd_state_q;
      unique case (rd_state_q)
         DSCG_RD_IDLE: begin
            if (ar_take) begin
               rd_state_d = DSCG_RD_RESP;
            end
         end
         DSCG_RD_RESP: begin
            if (s_axi_rready) begin
               rd_state_d = DSCG_RD_IDLE;
            end
         end
         default: begin
            rd_state_d = DSCG_RD_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------------------
   // gate register and unit outputs
   // ----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         deep_gate_q <= reg_to_units(`DSCG_DEEP_RESET);
         unit_clk_en_q <= '0;
         unit_access_fault_q <= '0;
         unit_access_ok_q <= '0;
         fault_cnt_q <= `DSCG_FCNT_ZERO;
      end else if (ce) begin
         deep_gate_q <= deep_gate_d;
         unit_clk_en_q <= sel_unit_en;
         unit_access_fault_q <= access_fault_now;
         unit_access_ok_q <= access_ok_now;
         fault_cnt_q <= fault_cnt_d;
      end
   end

   // ----------------------------------------------------------------------------
   // write channel registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_q <= DSCG_WR_IDLE;
         have_aw_q <= 1'b0;
         have_w_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= `DSCG_ZERO32;
         wstrb_q <= 4'h0;
         bresp_q <= `DSCG_RESP_OKAY;
      end else if (ce) begin
         wr_state_q <= wr_state_d;
         if (wr_fire) begin
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            bresp_q <= wr_mapped ? `DSCG_RESP_OKAY : `DSCG_RESP_SLVERR;
         end else begin
            if (aw_take) begin
               have_aw_q <= 1'b1;
               awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
               have_w_q <= 1'b1;
               wdata_q <= s_axi_wdata;
               wstrb_q <= s_axi_wstrb;
            end
         end
      end
   end

   // ----------------------------------------------------------------------------
   // read channel registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_q <= DSCG_RD_IDLE;
         rdata_q <= `DSCG_ZERO32;
         rresp_q <= `DSCG_RESP_OKAY;
      end else if (ce) begin
         rd_state_q <= rd_state_d;
         if (ar_take) begin
            rdata_q <= rd_value;
            rresp_q <= rd_mapped ? `DSCG_RESP_OKAY : `DSCG_RESP_SLVERR;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // ready flags, registered so every output comes from a flip-flop
   // ----------------------------------------------------------------------------
   // a master must stay idle while ce is low: a handshake seen then is not captured
   logic awready_q;
   logic wready_q;
   logic arready_q;
   logic bvalid_q;
   logic rvalid_q;

   wire wr_idle_next = (wr_state_d == DSCG_WR_IDLE);
   wire have_aw_next = !wr_fire && aw_ready_now;
   wire have_w_next = !wr_fire && w_ready_now;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         arready_q <= 1'b0;
         bvalid_q <= 1'b0;
         rvalid_q <= 1'b0;
      end else if (ce) begin
         awready_q <= wr_idle_next && !have_aw_next;
         wready_q <= wr_idle_next && !have_w_next;
         arready_q <= (rd_state_d == DSCG_RD_IDLE);
         bvalid_q <= (wr_state_d == DSCG_WR_RESP);
         rvalid_q <= (rd_state_d == DSCG_RD_RESP);
      end
   end

   // ----------------------------------------------------------------------------
   // output assignments
   // ----------------------------------------------------------------------------
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign unit_clk_en = unit_clk_en_q;
   assign unit_access_fault = unit_access_fault_q;
   assign unit_access_ok = unit_access_ok_q;
endmodule

// ===== pkg/dscg_defs.svh
// register map, field positions, reset values and widths of the deep-sleep clock gate bank
// assumes inclusion by bare name from the package and the design files
`ifndef DSCG_DEFS_SVH
`define DSCG_DEFS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define DSCG_OFF_DEEP_GATE 12'h120
`define DSCG_OFF_STATUS 12'h124
`define DSCG_OFF_FAULT_CNT 12'h128

// ----------------------------------------------------------------------------
// gate bit positions inside the gate register
// ----------------------------------------------------------------------------
`define DSCG_BIT_CAN_UNIT0_GATE 24
`define DSCG_BIT_ADC0 16
`define DSCG_BIT_HIB 6
`define DSCG_BIT_WDOG 3

// ----------------------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------------------
`define DSCG_DEEP_RESET 32'h00000040
`define DSCG_DEEP_WMASK 32'h01010048
`define DSCG_ZERO32 32'h00000000
`define DSCG_FCNT_W 16
`define DSCG_FCNT_ZERO 16'h0000

// ----------------------------------------------------------------------------
// unit indices in the unit vectors
// ----------------------------------------------------------------------------
`define DSCG_UNITS 4
`define DSCG_U_WDOG 0
`define DSCG_U_HIB 1
`define DSCG_U_ADC0 2
`define DSCG_U_CAN_UNIT0_GATE 3

// ----------------------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------------------
`define DSCG_RESP_OKAY 2'h0
`define DSCG_RESP_SLVERR 2'h2

`endif

// ===== pkg/dscg_pkg.sv
// types shared by the deep-sleep clock gate bank
// assumes dscg_defs.svh is on the include path
package dscg_pkg;
   `include "dscg_defs.svh"

   // system power mode supplied by the power controller
   typedef enum logic [1:0] {
      DSCG_PM_RUN = 2'h0,
      DSCG_PM_SLEEP = 2'h1,
      DSCG_PM_DEEP = 2'h2
   } dscg_pmode_t;

   // write channel handler states
   typedef enum logic [1:0] {
      DSCG_WR_IDLE = 2'b01,
      DSCG_WR_RESP = 2'b10
   } dscg_wr_state_t;

   // read channel handler states
   typedef enum logic [1:0] {
      DSCG_RD_IDLE = 2'b01,
      DSCG_RD_RESP = 2'b10
   } dscg_rd_state_t;
endpackage

// ===== rtl/dscg_gate_select.sv
// per-unit selection of the enable set that applies in the current power mode
// assumes all inputs come from logic on the same clock; purely combinational
module dscg_gate_select #(
   parameter int N = 4
) (
   input wire dscg_pkg::dscg_pmode_t power_mode,
   input wire logic auto_clock_gate_select,
   input wire logic [N-1:0] run_en,
   input wire logic [N-1:0] sleep_en,
   input wire logic [N-1:0] deep_en,
   output logic [N-1:0] unit_en
);
   import dscg_pkg::*;

   wire use_sleep;
   wire use_deep;

   // low-power sets only count when automatic gating is selected
   assign use_sleep = auto_clock_gate_select && (power_mode == DSCG_PM_SLEEP);
   assign use_deep = auto_clock_gate_select && (power_mode == DSCG_PM_DEEP);

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_unit
         // three independent sets, one chosen per unit
         assign unit_en[i] = use_deep ? deep_en[i] : (use_sleep ? sleep_en[i] : run_en[i]);
      end
   endgenerate
endmodule

// ===== tb/dscg_assertions.sv
// port checker for the deep-sleep clock gate bank
// assumes one clock aclk and bind onto every dscg_top instance
`include "dscg_defs.svh"
module dscg_assertions
   import dscg_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int N = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire dscg_pmode_t power_mode,
   input wire logic auto_clock_gate_select,
   input wire logic [N-1:0] run_gate_reg0,
   input wire logic [N-1:0] sleep_gate_reg0,
   input wire logic [N-1:0] unit_access_valid,
   input wire logic [N-1:0] unit_clk_en,
   input wire logic [N-1:0] unit_access_fault,
   input wire logic [N-1:0] unit_access_ok
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // properties on the design outputs
   // ----------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_unit_fault: assert property (
      ce |=> unit_access_fault == $past(unit_access_valid & ~unit_clk_en))
      else $error("fault pulse wrong");
   a_unit_ok: assert property (
      ce |=> unit_access_ok == $past(unit_access_valid & unit_clk_en))
      else $error("ok pulse wrong");
   a_run_set_rules: assert property (
      ce && !(auto_clock_gate_select && power_mode inside {DSCG_PM_SLEEP, DSCG_PM_DEEP})
      |=> unit_clk_en == $past(run_gate_reg0))
      else $error("run set not applied");
   a_sleep_set_rules: assert property (
      ce && auto_clock_gate_select && power_mode == DSCG_PM_SLEEP
      |=> unit_clk_en == $past(sleep_gate_reg0))
      else $error("sleep set not applied");
   a_reset_state: assert property (disable iff (1'b0)
      !aresetn |=> unit_clk_en == '0 && !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready)
      else $error("reset state wrong");
   a_reserved_zero: assert property (
      ce && s_axi_arvalid && s_axi_arready && (s_axi_araddr >> 2) == (`DSCG_OFF_DEEP_GATE >> 2)
      |=> (s_axi_rdata & ~`DSCG_DEEP_WMASK) == 32'h0 && s_axi_rresp == 2'h0)
      else $error("reserved bits not zero");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped");
   a_read_answer: assert property (
      ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
endmodule

bind dscg_top dscg_assertions #(.ADDR_W(ADDR_W), .N(N)) dscg_assertions_i (.aclk, .aresetn,
   .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_mode, .auto_clock_gate_select,
   .run_gate_reg0, .sleep_gate_reg0, .unit_access_valid, .unit_clk_en, .unit_access_fault,
   .unit_access_ok);

// ===== tb/dscg_axi_master.sv
// axi4-lite master standing in for processor software
// assumes one clock aclk; the bench calls wr and rd one at a time
module dscg_axi_master (
   input wire logic aclk,
   output logic [11:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [11:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // bus cycles; slow delays the response ready
   // ----------------------------------------
   int slow = 0;
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
         output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= (slow == 0);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
         if (n >= slow) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (slow == 0);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
         if (n >= slow) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule

// ===== tb/test_deep_sleep_clock_gate_bank0.sv
// self-checking bench for the deep-sleep clock gate bank
// assumes dscg_top, dscg_axi_master and the bound checker are compiled before it
module test_deep_sleep_clock_gate_bank0 import dscg_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic [2:0] prot = 3'h0;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, gate_q, rd_d, wd, m;
   logic [3:0] s_axi_wstrb, unit_clk_en, unit_access_fault, unit_access_ok, v, e;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   dscg_pmode_t power_mode = DSCG_PM_DEEP;
   logic auto_clock_gate_select = 1'b1;
   logic [3:0] run_gate_reg0 = 4'h0, sleep_gate_reg0 = 4'h0, unit_access_valid = 4'h0;
   int seed = 32'hD653CC4F;
   int n_mismatch = 0, n_checks = 0, cyc = 0, nf = 0;
   always #2 aclk = ~aclk;
   dscg_top dscg_top_i (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot(prot), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(prot), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_mode,
      .auto_clock_gate_select, .run_gate_reg0, .sleep_gate_reg0, .unit_access_valid,
      .unit_clk_en, .unit_access_fault, .unit_access_ok);
   dscg_axi_master dscg_axi_master_i (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   // ----------------------------------------
   // expectations, comparison and verdict
   // ----------------------------------------
   function automatic logic [3:0] units(input logic [31:0] g);
      return {g[24], g[16], g[6], g[3]};
   endfunction
   function automatic logic [3:0] sel(input logic [1:0] md, input logic a,
         input logic [3:0] r, input logic [3:0] s, input logic [3:0] d);
      if (a && md == 2'h2) return d;
      if (a && md == 2'h1) return s;
      return r;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         finish_test();
      end
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      @(negedge aclk);
      check(unit_clk_en, 4'h2);
      dscg_axi_master_i.rd(12'h120, rd_d, resp);
      check(rd_d, 32'h00000040);
      gate_q = 32'h00000040;
      dscg_axi_master_i.rd(12'h200, rd_d, resp);
      check(resp, 2'h2);
      dscg_axi_master_i.wr(12'h204, 32'hFFFFFFFF, 4'hF, resp);
      check(resp, 2'h2);
      dscg_axi_master_i.rd(12'h120, rd_d, resp);
      dscg_axi_master_i.wr(12'h120, rd_d | 32'h00000008, 4'hF, resp);
      gate_q = gate_q | 32'h00000008;
      for (int i = 0; i < 24; i++) begin
         dscg_axi_master_i.slow = i % 3;
         wd = (i == 0) ? 32'hFFFFFFFF : $random(seed);
         v = (i < 2) ? 4'hF : 4'($random(seed));
         dscg_axi_master_i.wr(12'h120, wd, v, resp);
         check(resp, 2'h0);
         m = {{8{v[3]}}, {8{v[2]}}, {8{v[1]}}, {8{v[0]}}} & 32'h01010048;
         gate_q = (gate_q & ~m) | (wd & m);
         dscg_axi_master_i.rd(12'h120, rd_d, resp);
         check(rd_d, gate_q);
         @(posedge aclk);
         power_mode <= dscg_pmode_t'(2'(i % 4));
         auto_clock_gate_select <= (i % 5 != 0);
         run_gate_reg0 <= 4'($random(seed));
         sleep_gate_reg0 <= 4'($random(seed));
         @(posedge aclk);
         @(negedge aclk);
         e = sel(power_mode, auto_clock_gate_select, run_gate_reg0, sleep_gate_reg0,
            units(gate_q));
         check(unit_clk_en, e);
         dscg_axi_master_i.rd(12'h124, rd_d, resp);
         check(rd_d, {7'h0, e[3], 7'h0, e[2], 9'h0, e[1], 2'h0, e[0], 3'h0});
         v = 4'($random(seed));
         @(posedge aclk);
         unit_access_valid <= v;
         @(posedge aclk);
         unit_access_valid <= 4'h0;
         @(negedge aclk);
         check(unit_access_fault, v & ~e);
         check(unit_access_ok, v & e);
         nf = nf + $countones(v & ~e);
      end
      dscg_axi_master_i.rd(12'h128, rd_d, resp);
      check(rd_d, nf);
      dscg_axi_master_i.wr(12'h128, 32'h0, 4'h1, resp);
      dscg_axi_master_i.rd(12'h128, rd_d, resp);
      check(rd_d, 32'h0);
      // ce low freezes the enables even though the run set changes
      @(posedge aclk);
      ce <= 1'b0;
      power_mode <= DSCG_PM_RUN;
      run_gate_reg0 <= ~e;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      check(unit_clk_en, e);
      @(posedge aclk);
      ce <= 1'b1;
      @(posedge aclk);
      @(negedge aclk);
      check(unit_clk_en, 4'(~e));
      finish_test();
   end
endmodule
